// File: a16_master_model.sv
// Behavioural A16 bus master: one-cycle strobe per access, byte lanes as enables.
// Assumes the block samples the strobe on the rising clock edge.
`timescale 1ns/100ps

module a16_master_model (
  input  wire        clk_in,    // Bus clock
  output reg         stb_out,   // Access strobe
  output reg  [15:0] addr_out,  // A16 address
  output reg         wr_out,    // Write access
  output reg         hi_out,    // Upper lane
  output reg         lo_out,    // Lower lane
  output reg  [15:0] wdata_out  // Write data
);
  initial begin
    {stb_out, addr_out, wr_out, hi_out, lo_out, wdata_out} = 36'h0;
  end

  task access(input [15:0] a, input w, input h, input l, input [15:0] d);
    begin
      @(negedge clk_in);
      {stb_out, addr_out, wr_out, hi_out, lo_out, wdata_out} = {1'b1, a, w, h, l, d};
      @(negedge clk_in);
      stb_out = 1'b0;
      // Released bus must not keep showing a valid-looking request
      addr_out = ~addr_out;
      wdata_out = ~wdata_out;
    end
  endtask

  task byte_write(input [15:0] a, input [15:0] d);
    begin
      access(a, 1'b1, 1'b1, 1'b0, d);
      access(a, 1'b1, 1'b0, 1'b1, d);
    end
  endtask
endmodule

// File: cfg_window_match.v
// Decodes one A16 address against the device's own logical address and
// the configuration-space window, for one direction of travel.
// Assumes all inputs are stable in the cycle that they are sampled.
`timescale 1ns/100ps
`include "config_space_window_map_regs.vh"

module cfg_window_match #(
  parameter INWARD = 0                   // 1: extension bus to VMEbus cycles
) (
  input  wire [15:0] addr_in,            // A16 address of the access
  input  wire [7:0]  own_la_in,          // Device's own logical address
  input  wire        enable_in,          // Window enable field
  input  wire        direction_in,       // Window direction field
  input  wire [2:0]  size_in,            // Window size field
  input  wire [7:0]  base_in,            // Window base field
  input  wire        compat_in,          // Alternate layout in force
  output wire        cfg_space_out,      // Address lies in configuration space
  output wire        own_hit_out,        // Address is the device's own block
  output wire        fwd_out             // Access passes through the window
);

  wire [7:0] la = addr_in[`A16_LA_MSB:`A16_LA_LSB];
  reg  [7:0] cmp_mask;
  integer    i;

  // Only the top size bits of the base take part in the compare
  always @* begin
    cmp_mask = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (i >= 8 - size_in)
        cmp_mask[i] = 1'b1;
    end
  end

  wire in_range = ((la ^ base_in) & cmp_mask) == 8'h00;
  // Range covers the selected direction, its complement the other one
  wire dir_ok   = INWARD ? (in_range == direction_in) : (in_range != direction_in);

  assign cfg_space_out = addr_in[`A16_SPACE_MSB:`A16_SPACE_LSB] == `A16_CFG_SPACE;
  assign own_hit_out   = cfg_space_out && (la == own_la_in);
  // Own decoder wins; the standard window is inert under the alternate layout
  assign fwd_out       = cfg_space_out && !own_hit_out && enable_in && !compat_in
                         && dir_ok;

endmodule

// File: config_space_window_map.v
// Configuration-space window of a bus extender: holds the window register
// in the device's own A16 block and decides, per access, whether a
// configuration cycle is answered locally or forwarded across the link.
// Assumes both access ports present one-cycle strobes synchronous to CLK_IN.
`timescale 1ns/100ps
`include "config_space_window_map_regs.vh"

module config_space_window_map (
  input  wire        CLK_IN,                // 10 MHz system clock
  input  wire        RST_N_IN,              // Hard reset, async, active low
  input  wire [7:0]  OWN_LA_IN,             // Device's own logical address
  input  wire        COMPAT_LAYOUT_MODE_IN, // Alternate register layout selected
  input  wire        VME_STB_IN,            // VMEbus A16 access strobe
  input  wire [15:0] VME_ADDR_IN,           // VMEbus A16 address
  input  wire        VME_WR_IN,             // VMEbus access is a write
  input  wire        VME_DS_HI_IN,          // VMEbus upper byte lane active
  input  wire        VME_DS_LO_IN,          // VMEbus lower byte lane active
  input  wire [15:0] VME_WDATA_IN,          // VMEbus write data
  output wire        VME_DONE_OUT,          // VMEbus access decoded
  output wire        VME_OWN_OUT,           // VMEbus access hits own block
  output wire        VME_REG_OUT,           // VMEbus access served by register
  output wire        VME_FWD_OUT,           // VMEbus access mapped outward
  output wire [15:0] VME_RDATA_OUT,         // VMEbus read data
  input  wire        EXT_STB_IN,            // Extension bus A16 access strobe
  input  wire [15:0] EXT_ADDR_IN,           // Extension bus A16 address
  input  wire        EXT_WR_IN,             // Extension access is a write
  input  wire        EXT_DS_HI_IN,          // Extension upper byte lane active
  input  wire        EXT_DS_LO_IN,          // Extension lower byte lane active
  input  wire [15:0] EXT_WDATA_IN,          // Extension write data
  output wire        EXT_DONE_OUT,          // Extension access decoded
  output wire        EXT_OWN_OUT,           // Extension access hits own block
  output wire        EXT_REG_OUT,           // Extension access served by register
  output wire        EXT_FWD_OUT,           // Extension access mapped inward
  output wire        EXT_RETRY_OUT,         // Extension register access refused
  output wire [15:0] EXT_RDATA_OUT,         // Extension read data
  output wire        WIN_ENABLE_OUT,        // Window enable in force
  output wire        WIN_DIR_OUT,           // Window direction in force
  output wire [2:0]  WIN_SIZE_OUT,          // Window size in force
  output wire [7:0]  WIN_BASE_OUT,          // Window base in force
  output wire        WIN_PENDING_OUT        // Upper byte staged, not yet applied
);

  // Fields in force for decoding
  reg        cfg_window_enable_ff;
  reg        cfg_window_direction_ff;
  reg  [2:0] cfg_window_size_ff;
  reg  [7:0] cfg_window_base_ff;
  // Last upper byte written; software reads this back
  reg        stage_enable_ff;
  reg        stage_direction_ff;
  reg  [2:0] stage_size_ff;
  reg        pending_ff;

  reg        vme_done_ff;
  reg        vme_own_ff;
  reg        vme_reg_ff;
  reg        vme_fwd_ff;
  reg [15:0] vme_rdata_ff;
  reg        ext_done_ff;
  reg        ext_own_ff;
  reg        ext_reg_ff;
  reg        ext_fwd_ff;
  reg        ext_retry_ff;
  reg [15:0] ext_rdata_ff;

  wire       vme_own;
  wire       vme_fwd;
  wire       ext_own;
  wire       ext_fwd;

  cfg_window_match #(
    .INWARD        (0)
  ) u_out_match (
    .addr_in       (VME_ADDR_IN),
    .own_la_in     (OWN_LA_IN),
    .enable_in     (cfg_window_enable_ff),
    .direction_in  (cfg_window_direction_ff),
    .size_in       (cfg_window_size_ff),
    .base_in       (cfg_window_base_ff),
    .compat_in     (COMPAT_LAYOUT_MODE_IN),
    .cfg_space_out (),
    .own_hit_out   (vme_own),
    .fwd_out       (vme_fwd)
  );

  cfg_window_match #(
    .INWARD        (1)
  ) u_in_match (
    .addr_in       (EXT_ADDR_IN),
    .own_la_in     (OWN_LA_IN),
    .enable_in     (cfg_window_enable_ff),
    .direction_in  (cfg_window_direction_ff),
    .size_in       (cfg_window_size_ff),
    .base_in       (cfg_window_base_ff),
    .compat_in     (COMPAT_LAYOUT_MODE_IN),
    .cfg_space_out (),
    .own_hit_out   (ext_own),
    .fwd_out       (ext_fwd)
  );

  // Register select: own block, word at the window offset, bit 0 is a lane
  wire vme_reg_sel = VME_STB_IN && vme_own && !COMPAT_LAYOUT_MODE_IN
                     && ({VME_ADDR_IN[`OWN_OFS_MSB:1], 1'b0} == `CSW_OFFSET);
  wire ext_reg_sel = EXT_STB_IN && ext_own && !COMPAT_LAYOUT_MODE_IN
                     && ({EXT_ADDR_IN[`OWN_OFS_MSB:1], 1'b0} == `CSW_OFFSET);
  // One register port: VMEbus wins a collision, the extension side retries
  wire ext_grant   = ext_reg_sel && !vme_reg_sel;

  reg        wr_hi;
  reg        wr_lo;
  reg [15:0] wdata;

  always @* begin
    wr_hi = 1'b0;
    wr_lo = 1'b0;
    wdata = 16'h0000;
    if (vme_reg_sel && VME_WR_IN) begin
      wr_hi = VME_DS_HI_IN;
      wr_lo = VME_DS_LO_IN;
      wdata = VME_WDATA_IN;
    end else if (ext_grant && EXT_WR_IN) begin
      wr_hi = EXT_DS_HI_IN;
      wr_lo = EXT_DS_LO_IN;
      wdata = EXT_WDATA_IN;
    end
  end

  // Readback shows the staged upper byte, so a byte master sees its own write
  wire [15:0] rd_word = {`CSW_RSV_TOP_VAL, stage_enable_ff, stage_direction_ff,
                         `CSW_RSV_VAL, stage_size_ff, cfg_window_base_ff};

  function [15:0] lane_mask;
    input [15:0] word;
    input        hi;
    input        lo;
    begin
      lane_mask = {hi ? word[15:8] : 8'h00, lo ? word[7:0] : 8'h00};
    end
  endfunction

  // Only the hard reset reaches these; a soft reset has no path here
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg_window_enable_ff    <= `CSW_EN_RST;
      cfg_window_direction_ff <= `CSW_DIR_RST;
      cfg_window_size_ff      <= `CSW_SIZE_RST;
      cfg_window_base_ff      <= `CSW_BASE_RST;
      stage_enable_ff         <= `CSW_EN_RST;
      stage_direction_ff      <= `CSW_DIR_RST;
      stage_size_ff           <= `CSW_SIZE_RST;
      pending_ff              <= 1'b0;
    end else begin
      // Bits 15, 12 and 11 of the write data are dropped here
      if (wr_hi) begin
        stage_enable_ff    <= wdata[`CSW_EN_BIT];
        stage_direction_ff <= wdata[`CSW_DIR_BIT];
        stage_size_ff      <= wdata[`CSW_SIZE_MSB:`CSW_SIZE_LSB];
      end
      if (wr_lo) begin
        cfg_window_base_ff <= wdata[`CSW_BASE_MSB:`CSW_BASE_LSB];
        // Lower byte commits the upper byte, staged or written alongside
        if (wr_hi) begin
          cfg_window_enable_ff    <= wdata[`CSW_EN_BIT];
          cfg_window_direction_ff <= wdata[`CSW_DIR_BIT];
          cfg_window_size_ff      <= wdata[`CSW_SIZE_MSB:`CSW_SIZE_LSB];
        end else begin
          cfg_window_enable_ff    <= stage_enable_ff;
          cfg_window_direction_ff <= stage_direction_ff;
          cfg_window_size_ff      <= stage_size_ff;
        end
        pending_ff <= 1'b0;
      end else if (wr_hi) begin
        pending_ff <= 1'b1;
      end
    end
  end

  // VMEbus answer, one cycle after the strobe
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      vme_done_ff  <= 1'b0;
      vme_own_ff   <= 1'b0;
      vme_reg_ff   <= 1'b0;
      vme_fwd_ff   <= 1'b0;
      vme_rdata_ff <= 16'h0000;
    end else begin
      vme_done_ff <= VME_STB_IN;
      vme_own_ff  <= VME_STB_IN && vme_own;
      vme_reg_ff  <= vme_reg_sel;
      vme_fwd_ff  <= VME_STB_IN && vme_fwd;
      if (VME_STB_IN) begin
        if (vme_reg_sel && !VME_WR_IN)
          vme_rdata_ff <= lane_mask(rd_word, VME_DS_HI_IN, VME_DS_LO_IN);
        else
          vme_rdata_ff <= 16'h0000;
      end
    end
  end

  // Extension bus answer, one cycle after the strobe
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ext_done_ff  <= 1'b0;
      ext_own_ff   <= 1'b0;
      ext_reg_ff   <= 1'b0;
      ext_fwd_ff   <= 1'b0;
      ext_retry_ff <= 1'b0;
      ext_rdata_ff <= 16'h0000;
    end else begin
      ext_done_ff  <= EXT_STB_IN;
      ext_own_ff   <= EXT_STB_IN && ext_own;
      ext_reg_ff   <= ext_grant;
      ext_fwd_ff   <= EXT_STB_IN && ext_fwd;
      ext_retry_ff <= ext_reg_sel && vme_reg_sel;
      if (EXT_STB_IN) begin
        if (ext_grant && !EXT_WR_IN)
          ext_rdata_ff <= lane_mask(rd_word, EXT_DS_HI_IN, EXT_DS_LO_IN);
        else
          ext_rdata_ff <= 16'h0000;
      end
    end
  end

  assign VME_DONE_OUT    = vme_done_ff;
  assign VME_OWN_OUT     = vme_own_ff;
  assign VME_REG_OUT     = vme_reg_ff;
  assign VME_FWD_OUT     = vme_fwd_ff;
  assign VME_RDATA_OUT   = vme_rdata_ff;
  assign EXT_DONE_OUT    = ext_done_ff;
  assign EXT_OWN_OUT     = ext_own_ff;
  assign EXT_REG_OUT     = ext_reg_ff;
  assign EXT_FWD_OUT     = ext_fwd_ff;
  assign EXT_RETRY_OUT   = ext_retry_ff;
  assign EXT_RDATA_OUT   = ext_rdata_ff;
  assign WIN_ENABLE_OUT  = cfg_window_enable_ff;
  assign WIN_DIR_OUT     = cfg_window_direction_ff;
  assign WIN_SIZE_OUT    = cfg_window_size_ff;
  assign WIN_BASE_OUT    = cfg_window_base_ff;
  assign WIN_PENDING_OUT = pending_ff;

endmodule

// File: config_space_window_map_checker.sv
// Concurrent checks on the window block, seen from its top-level ports.
// Assumes one clock domain and the hard reset as the only reset.
`timescale 1ns/100ps

module config_space_window_map_checker (
  input wire        CLK_IN,                // Clock
  input wire        RST_N_IN,              // Hard reset
  input wire        COMPAT_LAYOUT_MODE_IN, // Alternate layout
  input wire        VME_STB_IN,            // VME strobe
  input wire [15:0] VME_ADDR_IN,           // VME address
  input wire        VME_WR_IN,             // VME write
  input wire        VME_DS_HI_IN,          // VME upper lane
  input wire        VME_DS_LO_IN,          // VME lower lane
  input wire        VME_DONE_OUT,          // VME done
  input wire        VME_OWN_OUT,           // VME own hit
  input wire        VME_REG_OUT,           // VME register hit
  input wire        VME_FWD_OUT,           // VME outward
  input wire [15:0] VME_RDATA_OUT,         // VME read data
  input wire        EXT_STB_IN,            // EXT strobe
  input wire [15:0] EXT_ADDR_IN,           // EXT address
  input wire        EXT_FWD_OUT,           // EXT inward
  input wire        WIN_ENABLE_OUT,        // Enable in force
  input wire [2:0]  WIN_SIZE_OUT,          // Size in force
  input wire        WIN_PENDING_OUT        // Upper byte staged
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_hi_wr;
    VME_STB_IN && VME_WR_IN && VME_DS_HI_IN && !VME_DS_LO_IN ##1 VME_REG_OUT;
  endsequence
  sequence s_lo_wr;
    VME_STB_IN && VME_WR_IN && VME_DS_LO_IN ##1 VME_REG_OUT;
  endsequence
  sequence s_hi_rd;
    VME_STB_IN && !VME_WR_IN && VME_DS_HI_IN ##1 VME_REG_OUT;
  endsequence
  sequence s_same_la;
    VME_STB_IN && EXT_STB_IN && VME_ADDR_IN == EXT_ADDR_IN && VME_ADDR_IN[15:14] == 2'h3
      && WIN_ENABLE_OUT && !COMPAT_LAYOUT_MODE_IN ##1 !VME_OWN_OUT;
  endsequence

  AST_DONE_NEXT: assert property (VME_STB_IN |=> VME_DONE_OUT)
    else $error("done missing after strobe");
  AST_OWN_BEATS_WINDOW: assert property (VME_OWN_OUT |-> !VME_FWD_OUT)
    else $error("own access forwarded");
  AST_LO_BYTE_COMMITS: assert property (s_lo_wr |-> !WIN_PENDING_OUT)
    else $error("lower byte write left pending");
  AST_HI_BYTE_STAGES: assert property (s_hi_wr |-> WIN_PENDING_OUT && $stable(WIN_ENABLE_OUT))
    else $error("upper byte write took effect early");
  AST_READ_RESERVED: assert property (s_hi_rd |-> VME_RDATA_OUT[15] == 1'b0 && VME_RDATA_OUT[12:11] == 2'h3)
    else $error("reserved bits read wrong");
  AST_DISABLED_NO_FWD: assert property (VME_STB_IN && !WIN_ENABLE_OUT |=> !VME_FWD_OUT)
    else $error("forward with window disabled");
  AST_OPPOSITE_DIRS: assert property (s_same_la |-> VME_FWD_OUT != EXT_FWD_OUT)
    else $error("address not mapped in exactly one direction");
  AST_CFG_QUARTER_ONLY: assert property (VME_STB_IN && VME_ADDR_IN[15:14] != 2'h3 |=> !VME_FWD_OUT && !VME_OWN_OUT)
    else $error("lower A16 forwarded by window");
  AST_HARD_RESET_CLEARS: assert property ($rose(RST_N_IN) |-> !WIN_ENABLE_OUT && WIN_SIZE_OUT == 3'h0 && !WIN_PENDING_OUT)
    else $error("fields not cleared by reset");
  AST_COMPAT_NO_REG: assert property (COMPAT_LAYOUT_MODE_IN && VME_STB_IN |=> !VME_REG_OUT && !VME_FWD_OUT)
    else $error("register answered in alternate layout");
endmodule

bind config_space_window_map config_space_window_map_checker u_chk (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .COMPAT_LAYOUT_MODE_IN(COMPAT_LAYOUT_MODE_IN),
  .VME_STB_IN(VME_STB_IN), .VME_ADDR_IN(VME_ADDR_IN), .VME_WR_IN(VME_WR_IN),
  .VME_DS_HI_IN(VME_DS_HI_IN), .VME_DS_LO_IN(VME_DS_LO_IN), .VME_DONE_OUT(VME_DONE_OUT),
  .VME_OWN_OUT(VME_OWN_OUT), .VME_REG_OUT(VME_REG_OUT), .VME_FWD_OUT(VME_FWD_OUT),
  .VME_RDATA_OUT(VME_RDATA_OUT), .EXT_STB_IN(EXT_STB_IN), .EXT_ADDR_IN(EXT_ADDR_IN),
  .EXT_FWD_OUT(EXT_FWD_OUT), .WIN_ENABLE_OUT(WIN_ENABLE_OUT), .WIN_SIZE_OUT(WIN_SIZE_OUT),
  .WIN_PENDING_OUT(WIN_PENDING_OUT));

// File: config_space_window_map_regs.vh
// Constants for the configuration-space window: offsets, field positions,
// reset values and the address layout of the upper quarter of A16 space.
// Assumes inclusion by bare name from the window design files only.
`ifndef CONFIG_SPACE_WINDOW_MAP_REGS_VH
`define CONFIG_SPACE_WINDOW_MAP_REGS_VH

// Byte offset of the window register inside the device's own A16 block
`define CSW_OFFSET        6'h0A
// Top bit of the offset inside the device's own 64-byte A16 block
`define OWN_OFS_MSB       5

// Field positions inside the 16-bit register
`define CSW_RSV_TOP_BIT   15
`define CSW_EN_BIT        14
`define CSW_DIR_BIT       13
`define CSW_RSV_MSB       12
`define CSW_RSV_LSB       11
`define CSW_SIZE_MSB      10
`define CSW_SIZE_LSB      8
`define CSW_BASE_MSB      7
`define CSW_BASE_LSB      0

// Read values of the reserved fields
`define CSW_RSV_TOP_VAL   1'h0
`define CSW_RSV_VAL       2'h3

// Hard reset values of the stored fields
`define CSW_EN_RST        1'h0
`define CSW_DIR_RST       1'h0
`define CSW_SIZE_RST      3'h0
`define CSW_BASE_RST      8'h00

// A16 address layout: upper quarter is configuration space,
// lines 13..6 carry the logical address
`define A16_SPACE_MSB     15
`define A16_SPACE_LSB     14
`define A16_CFG_SPACE     2'h3
`define A16_LA_MSB        13
`define A16_LA_LSB        6

`endif

// File: config_space_window_map_tb.sv
// Self-checking bench for the configuration-space window block.
// Assumes two bus master models, own logical address fixed at 55 hex.
`timescale 1ns/100ps

module config_space_window_map_tb;
  localparam [15:0] REG = 16'hD54A;
  reg         clk, rst_n, compat;
  reg  [7:0]  own_la;
  wire        v_stb, v_wr, v_hi, v_lo, e_stb, e_wr, e_hi, e_lo, w_en, w_dir, w_pend;
  wire [15:0] v_addr, v_wd, v_rd, e_addr, e_wd, e_rd;
  wire        v_done, v_own, v_reg, v_fwd, e_done, e_own, e_reg, e_fwd, e_retry;
  wire [2:0]  w_size;
  wire [7:0]  w_base;
  integer     fail_count, tests_run, i;

  config_space_window_map DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .OWN_LA_IN(own_la),
    .COMPAT_LAYOUT_MODE_IN(compat), .VME_STB_IN(v_stb), .VME_ADDR_IN(v_addr),
    .VME_WR_IN(v_wr), .VME_DS_HI_IN(v_hi), .VME_DS_LO_IN(v_lo), .VME_WDATA_IN(v_wd),
    .VME_DONE_OUT(v_done), .VME_OWN_OUT(v_own), .VME_REG_OUT(v_reg), .VME_FWD_OUT(v_fwd),
    .VME_RDATA_OUT(v_rd), .EXT_STB_IN(e_stb), .EXT_ADDR_IN(e_addr), .EXT_WR_IN(e_wr),
    .EXT_DS_HI_IN(e_hi), .EXT_DS_LO_IN(e_lo), .EXT_WDATA_IN(e_wd), .EXT_DONE_OUT(e_done),
    .EXT_OWN_OUT(e_own), .EXT_REG_OUT(e_reg), .EXT_FWD_OUT(e_fwd), .EXT_RETRY_OUT(e_retry),
    .EXT_RDATA_OUT(e_rd), .WIN_ENABLE_OUT(w_en), .WIN_DIR_OUT(w_dir), .WIN_SIZE_OUT(w_size),
    .WIN_BASE_OUT(w_base), .WIN_PENDING_OUT(w_pend));
  a16_master_model vm (.clk_in(clk), .stb_out(v_stb), .addr_out(v_addr), .wr_out(v_wr),
    .hi_out(v_hi), .lo_out(v_lo), .wdata_out(v_wd));
  a16_master_model em (.clk_in(clk), .stb_out(e_stb), .addr_out(e_addr), .wr_out(e_wr),
    .hi_out(e_hi), .lo_out(e_lo), .wdata_out(e_wd));

  task check(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task t_reset_read;
    begin
      vm.access(REG, 1'b0, 1'b1, 1'b1, 16'h0000);
      check({v_done, v_own, v_reg}, 3'h7);
      check(v_rd, 16'h1800);
      check({w_en, w_dir, w_size, w_base, w_pend}, 14'h0);
    end
  endtask

  task t_word_access;
    begin
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'hFFFF);
      check({w_en, w_dir, w_size, w_base}, 13'h1FFF);
      vm.access(REG, 1'b0, 1'b1, 1'b1, 16'h0000);
      check(v_rd, 16'h7FFF);
      vm.access(REG, 1'b0, 1'b0, 1'b1, 16'h0000);
      check(v_rd, 16'h00FF);
      em.access(REG, 1'b0, 1'b1, 1'b1, 16'h0000);
      check({e_done, e_own, e_reg, e_fwd}, 4'hE);
      check(e_rd, 16'h7FFF);
      em.access(REG, 1'b1, 1'b1, 1'b1, 16'h0000);
      check({e_own, e_reg, e_retry}, 3'h6);
      check({w_en, w_dir, w_size, w_base}, 13'h0000);
      // Same-cycle register accesses: VMEbus is served, extension side refused
      fork
        vm.access(REG, 1'b0, 1'b1, 1'b1, 16'h0000);
        em.access(REG, 1'b1, 1'b1, 1'b1, 16'hFFFF);
      join
      check({v_reg, e_own, e_reg, e_retry}, 4'hD);
      check(v_rd, 16'h1800);
      check({w_en, w_dir, w_size, w_base, w_pend}, 14'h0000);
    end
  endtask

  task t_byte_write;
    begin
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'h0000);
      vm.access(REG, 1'b1, 1'b1, 1'b0, 16'h46AA);
      check({w_pend, w_en, w_size}, 5'h10);
      vm.access(REG, 1'b1, 1'b0, 1'b1, 16'hAA55);
      check({w_pend, w_en, w_dir, w_size, w_base}, {3'b010, 3'h6, 8'h55});
    end
  endtask

  task t_window(input dir);
    reg hit;
    begin
      for (i = 8'h50; i < 8'h5C; i = i + 1) begin
        fork
          vm.access({2'h3, i[7:0], 6'h00}, 1'b0, 1'b1, 1'b1, 16'h0000);
          em.access({2'h3, i[7:0], 6'h00}, 1'b0, 1'b1, 1'b1, 16'h0000);
        join
        hit = (i[7:2] == 6'h15);
        if (i == 8'h55)
          check({v_own, v_fwd, e_fwd}, 3'h4);
        else
          check({v_fwd, e_fwd}, {hit ^ dir, ~(hit ^ dir)});
      end
    end
  endtask

  task t_edges;
    begin
      vm.access(16'h1540, 1'b0, 1'b1, 1'b1, 16'h0000);
      check({v_own, v_fwd}, 2'h0);
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'h4055);
      vm.access(16'hFFC0, 1'b0, 1'b1, 1'b1, 16'h0000);
      check(v_fwd, 1'b1);
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'h0655);
      fork
        vm.access(16'hD500, 1'b0, 1'b1, 1'b1, 16'h0000);
        em.access(16'hD500, 1'b0, 1'b1, 1'b1, 16'h0000);
      join
      check({v_fwd, e_fwd}, 2'h0);
    end
  endtask

  task t_compat_and_reset;
    begin
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'h7FFF);
      vm.access(16'hC000, 1'b0, 1'b1, 1'b1, 16'h0000);
      check(v_fwd, 1'b1);
      compat = 1'b1;
      vm.access(REG, 1'b0, 1'b1, 1'b1, 16'h0000);
      check({v_own, v_reg}, 2'h2);
      vm.access(REG, 1'b1, 1'b1, 1'b1, 16'h0000);
      vm.access(16'hC000, 1'b0, 1'b1, 1'b1, 16'h0000);
      check({v_own, v_fwd}, 2'h0);
      compat = 1'b0;
      check({w_en, w_dir, w_size, w_base}, 13'h1FFF);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      t_reset_read;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count = fail_count + 1;
    complete_run;
  end

  initial begin
    {rst_n, compat, own_la, fail_count, tests_run} = {2'b00, 8'h55, 32'd0, 32'd0};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset_read;
    t_word_access;
    t_byte_write;
    t_window(1'b0);
    vm.byte_write(REG, 16'h6655);
    t_window(1'b1);
    t_edges;
    t_compat_and_reset;
    complete_run;
  end
endmodule
